// ### rtl/lpp_top.sv
// eight-line bit-independent port with strobe-latched input option
`timescale 1ns/10ps
module lpp_top #(
  parameter int WIDTH = 8
) (
  input  wire logic             REF_CLK_I,
  input  wire logic             SYS_RST_I,
  input  wire logic [7:0]       MODE_CTRL_I,
  input  wire logic             INPUT_STROBE_PIN_I,
  input  wire logic             PORT_WR_I,
  input  wire logic [WIDTH-1:0] PORT_WDATA_I,
  input  wire logic             PORT_RD_I,
  input  wire logic             PORT_RMW_I,
  input  wire logic [WIDTH-1:0] PORT_PINS_I,
  output logic      [WIDTH-1:0] PORT_PINS_O,
  output logic      [WIDTH-1:0] PORT_PINS_OE_O,
  output logic      [WIDTH-1:0] PORT_RDATA_O,
  output logic                  PORT_RVALID_O
);
  if (WIDTH != lpp_pkg::PORT_WIDTH) begin : g_width_check
    $error("lpp_top only serves an eight-line port");
  end
  if (lpp_pkg::MODE_WIDTH <= lpp_pkg::LATCH_EN_BIT) begin : g_mode_check
    $error("mode word has no latch enable bit");
  end

  logic             latch_en;
  logic             strobe_q;
  logic             cap;
  logic [WIDTH-1:0] port_reg_q;
  logic [WIDTH-1:0] latch_data;
  logic [WIDTH-1:0] rdata_d;
  logic [WIDTH-1:0] line_val;
  logic [WIDTH-1:0] pins_d;
  logic [WIDTH-1:0] oe_d;
  lpp_pkg::lpp_rdsel_t rdsel;

  assign latch_en = MODE_CTRL_I[lpp_pkg::LATCH_EN_BIT];
  // capture on rising edge of the strobe pulse
  assign cap      = latch_en && INPUT_STROBE_PIN_I && !strobe_q;

  function automatic lpp_pkg::lpp_rdsel_t sel_read(input logic en, input logic rmw);
    if (rmw) begin
      sel_read = lpp_pkg::LPP_RD_REG;
    end else if (en) begin
      sel_read = lpp_pkg::LPP_RD_LATCH;
    end else begin
      sel_read = lpp_pkg::LPP_RD_PINS;
    end
  endfunction

  // a line is pulled low only in bidirectional use with its bit at zero
  function automatic logic drives_low(input logic en, input logic val);
    drives_low = !en && !val;
  endfunction

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= INPUT_STROBE_PIN_I;
    end
  end

  // port output register
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      port_reg_q <= lpp_pkg::PORT_RESET_VAL;
    end else if (PORT_WR_I) begin
      port_reg_q <= PORT_WDATA_I;
    end
  end

  lpp_latch #(
    .WIDTH (WIDTH)
  ) u_latch (
    .clk_i  (REF_CLK_I),
    .rst_i  (SYS_RST_I),
    .cap_i  (cap),
    .pins_i (PORT_PINS_I),
    .data_o (latch_data)
  );

  // outside latched mode, a write shows on the pins at the same edge that stores it
  assign line_val = PORT_WR_I ? PORT_WDATA_I : port_reg_q;

  // per-line drive: only a zero is actively driven, a one leaves the pull-up
  for (genvar i = 0; i < WIDTH; i++) begin : g_line
    assign pins_d[i] = line_val[i] && !latch_en;
    assign oe_d[i]   = drives_low(latch_en, line_val[i]);

    a_line_drive: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !latch_en && !PORT_WR_I |=> PORT_PINS_OE_O[i] == !$past(port_reg_q[i]))
      else $error("line drive does not follow its register bit");
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PORT_PINS_O    <= '0;
      PORT_PINS_OE_O <= '0;
    end else begin
      PORT_PINS_O    <= pins_d;
      PORT_PINS_OE_O <= oe_d;
    end
  end

  always_comb begin
    rdsel = sel_read(latch_en, PORT_RMW_I);
    case (rdsel)
      lpp_pkg::LPP_RD_REG:   rdata_d = port_reg_q;
      lpp_pkg::LPP_RD_LATCH: rdata_d = latch_data;
      lpp_pkg::LPP_RD_PINS:  rdata_d = PORT_PINS_I;
      default:               rdata_d = PORT_PINS_I;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PORT_RVALID_O <= 1'b0;
    end else begin
      PORT_RVALID_O <= PORT_RD_I;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PORT_RDATA_O <= '0;
    end else if (PORT_RD_I) begin
      PORT_RDATA_O <= rdata_d;
    end
  end

  a_reset_ones: assert property (@(posedge REF_CLK_I)
    $past(SYS_RST_I) |-> port_reg_q == lpp_pkg::PORT_RESET_VAL)
    else $error("port register not all ones after reset");
  a_latch_inputs: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    $past(latch_en) && !$past(SYS_RST_I) |-> PORT_PINS_OE_O == '0)
    else $error("pin driven in latched mode");
  a_strobe_capture: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cap |=> latch_data == $past(PORT_PINS_I))
    else $error("strobe did not capture lines");
  a_latch_hold: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !latch_en |=> $stable(latch_data))
    else $error("latch changed outside latched mode");
  a_read_latch: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I && latch_en && !PORT_RMW_I |=> PORT_RDATA_O == $past(latch_data))
    else $error("latched read wrong");
  a_read_pins: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I && !latch_en && !PORT_RMW_I |=> PORT_RDATA_O == $past(PORT_PINS_I))
    else $error("plain read not pin levels");
  a_read_rmw: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I && PORT_RMW_I |=> PORT_RDATA_O == $past(port_reg_q))
    else $error("rmw read not register");
  a_drive_zero: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_WR_I && !latch_en ##1 !latch_en |-> PORT_PINS_OE_O == ~$past(PORT_WDATA_I))
    else $error("output enable does not follow written zeros");
  a_write_store: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_WR_I |=> port_reg_q == $past(PORT_WDATA_I))
    else $error("port register not written");
  a_rvalid_pulse: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I |=> PORT_RVALID_O)
    else $error("read answer missing");

  a_oe_reset: assert property (@(posedge REF_CLK_I)
    $past(SYS_RST_I) |-> PORT_PINS_OE_O == '0 && !PORT_RVALID_O)
    else $error("outputs not idle after reset");
  a_reg_hold: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !PORT_WR_I |=> $stable(port_reg_q))
    else $error("port register changed without a write");

  a_pins_follow: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !latch_en && !PORT_WR_I |=> PORT_PINS_O == $past(port_reg_q))
    else $error("pin value does not follow register");
  a_plain_drive: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !latch_en && !PORT_WR_I |=> PORT_PINS_OE_O == ~$past(port_reg_q))
    else $error("bidirectional drive does not follow register");
  a_drive_low_only: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (PORT_PINS_OE_O & PORT_PINS_O) == '0)
    else $error("a line is driven high");
  a_latched_write: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    latch_en && PORT_WR_I |=> PORT_PINS_OE_O == '0)
    else $error("write drove a line in latched mode");

  a_latch_steady: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !cap |=> $stable(latch_data))
    else $error("latch changed without a strobe");
  a_capture_edge: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    latch_en && INPUT_STROBE_PIN_I && !$past(INPUT_STROBE_PIN_I)
      |=> latch_data == $past(PORT_PINS_I))
    else $error("strobe edge did not capture lines");
  a_strobe_track: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !$past(SYS_RST_I) |-> strobe_q == $past(INPUT_STROBE_PIN_I))
    else $error("strobe sample lost");

  a_rvalid_only: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !PORT_RD_I |=> !PORT_RVALID_O)
    else $error("read answer without a request");
  a_rdata_hold: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !PORT_RD_I |=> $stable(PORT_RDATA_O))
    else $error("read data changed without a read");
  a_rmw_latched: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I && PORT_RMW_I && latch_en |=> PORT_RDATA_O == $past(port_reg_q))
    else $error("rmw read in latched mode not register");

  c_capture:   cover property (@(posedge REF_CLK_I) disable iff (SYS_RST_I) cap);
  c_rmw_read:  cover property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_RD_I && PORT_RMW_I);
  c_latch_rd:  cover property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    cap ##[1:4] (PORT_RD_I && latch_en));
  c_drive_out: cover property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    PORT_WR_I && !latch_en ##1 PORT_PINS_OE_O != '0);
  c_mode_leave: cover property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
    $fell(latch_en) ##1 PORT_PINS_OE_O != '0);
endmodule

// ### rtl/lpp_pkg.sv
// package of constants for the latched parallel input port
package lpp_pkg;
  localparam int          PORT_WIDTH      = 8;
  localparam logic [7:0]  PORT_RESET_VAL  = 8'hFF;
  localparam logic [7:0]  LATCH_RESET_VAL = 8'h00;
  localparam int          MODE_WIDTH      = 8;
  localparam int          LATCH_EN_BIT    = 4;
  typedef enum logic [1:0] {
    LPP_RD_PINS,
    LPP_RD_REG,
    LPP_RD_LATCH
  } lpp_rdsel_t;
endpackage

// ### rtl/lpp_latch.sv
// strobe-captured input latch of the port
`timescale 1ns/10ps
module lpp_latch #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cap_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] data_o
);
  if (WIDTH < 1) begin : g_width_check
    $error("lpp_latch width must be positive");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= WIDTH'(lpp_pkg::LATCH_RESET_VAL);
    end else if (cap_i) begin
      data_o <= pins_i;
    end
  end
endmodule

// ### testbench/lpp_peer.sv
// far-side equipment model: drives the port lines and pulses the strobe
`timescale 1ns/10ps
module lpp_peer (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] data_i,
  input  wire logic [3:0] dly_i,
  output logic      [7:0] drv_o,
  output logic            en_o,
  output logic            stb_o
);
  initial begin
    drv_o = 8'h00;
    en_o  = 1'b0;
    stb_o = 1'b0;
  end
  always begin
    @(posedge clk_i iff go_i);
    @(negedge clk_i);
    en_o  = 1'b1;
    drv_o = data_i;
    repeat (dly_i) @(negedge clk_i);
    stb_o = 1'b1;
    @(negedge clk_i);
    stb_o = 1'b0;
    @(negedge clk_i);
    en_o  = 1'b0;
    drv_o = ~data_i;
  end
endmodule

// ### testbench/latched_parallel_input_port_bench.sv
// self-checking bench of the latched parallel input port
`timescale 1ns/10ps
module latched_parallel_input_port_bench;
  logic       clk, rst, wr, rd_q, rmw, go, stb, p_en, rv;
  logic [7:0] mode, wd, p_drv, p_data, oe, po, pins, rdat, w, d;
  logic [3:0] dly;
  logic [7:0] q[$];
  int         n_errors, n_checks, cyc;
  assign pins = (p_en ? p_drv : 8'hFF) & ~(oe & ~po);
  lpp_top uut (.REF_CLK_I(clk), .SYS_RST_I(rst), .MODE_CTRL_I(mode),
    .INPUT_STROBE_PIN_I(stb), .PORT_WR_I(wr), .PORT_WDATA_I(wd), .PORT_RD_I(rd_q),
    .PORT_RMW_I(rmw), .PORT_PINS_I(pins), .PORT_PINS_O(po), .PORT_PINS_OE_O(oe),
    .PORT_RDATA_O(rdat), .PORT_RVALID_O(rv));
  lpp_peer peer (.clk_i(clk), .go_i(go), .data_i(p_data), .dly_i(dly), .drv_o(p_drv),
    .en_o(p_en), .stb_o(stb));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task rd(input logic r, input logic [7:0] exp);
    @(negedge clk);
    rd_q = 1'b1;
    rmw  = r;
    q.push_back(exp);
    @(negedge clk);
    rd_q = 1'b0;
    rmw  = 1'b0;
  endtask
  task wrt(input logic [7:0] v);
    @(negedge clk);
    wr = 1'b1;
    wd = v;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task send(input logic [7:0] v, input logic [3:0] n);
    @(negedge clk);
    go     = 1'b1;
    p_data = v;
    dly    = n;
    @(negedge clk);
    go = 1'b0;
    repeat (n + 4) @(negedge clk);
  endtask
  task set_mode(input logic latch);
    @(negedge clk);
    mode    = 8'($urandom);
    mode[4] = latch;
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) begin
        chk(8'h01, 8'h00);
      end else begin
        chk(rdat, q.pop_front());
      end
    end
  end
  initial begin
    {wr, rd_q, rmw, go, mode, wd, p_data, dly} = '0;
    rst = 1'b1;
    void'($urandom(1779));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(oe, 8'h00);
    rd(1'b0, 8'hFF);
    rd(1'b1, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      w = 8'($urandom);
      wrt(w);
      chk(oe, ~w);
      chk(po, w);
      rd(1'b0, w);
      rd(1'b1, w);
    end
    wrt(8'h00);
    set_mode(1'b1);
    chk(oe, 8'h00);
    chk(po, 8'h00);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      send(d, 4'(3 * i));
      rd(1'b0, d);
      rd(1'b1, 8'h00);
    end
    set_mode(1'b0);
    chk(oe, 8'hFF);
    chk(po, 8'h00);
    rd(1'b0, 8'h00);
    wrt(8'hFF);
    send(~d, 4'd1);
    set_mode(1'b1);
    rd(1'b0, d);
    wrt(8'h3C);
    chk(oe, 8'h00);
    rd(1'b1, 8'h3C);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk(oe, 8'h00);
    rd(1'b1, 8'hFF);
    rd(1'b0, 8'h00);
    repeat (3) @(negedge clk);
    chk(8'(q.size()), 8'h00);
    close_out();
  end
endmodule
